// File: design/ifd_regs.vh
`ifndef IFD_REGS_VH
`define IFD_REGS_VH
// ----------------------------------------------------------------
// register map (byte offsets inside the slave window)
// ----------------------------------------------------------------
`define IFD_A_CTRL 8'h00
`define IFD_A_STAT 8'h04
`define IFD_A_LAST 8'h08
`define IFD_A_CNT 8'h0c
`define IFD_A_WORD 7:2
`define IFD_A_LOW 7:0
`define IFD_CTRL_RST 3'h4
`define IFD_C_MODE 1:0
`define IFD_C_EN 2
`define IFD_C_BITS 2:0
`define IFD_S_WAIT 0
`define IFD_S_ILL 1
`define IFD_S_GRP 3:2
`define IFD_L_WORD 15:0
`define IFD_L_ADDR 31:16
// ----------------------------------------------------------------
// addressing modes
// ----------------------------------------------------------------
`define IFD_M_16S 2'h0
`define IFD_M_32S 2'h1
`define IFD_M_32R 2'h2
`define IFD_M_64R 2'h3
`define IFD_M_REL 1
// ----------------------------------------------------------------
// instruction fields; word bit 1 is vector bit 15
// ----------------------------------------------------------------
`define IFD_F_IND 15
`define IFD_F_IDX 14
`define IFD_F_SUB 15:14
`define IFD_F_OPC 13:10
`define IFD_F_TOP 15:10
`define IFD_F_SEC 9
`define IFD_F_DISP 8:0
`define IFD_F_SOP 15:6
`define IFD_F_SCNT 5:0
`define IFD_F_IOFN 9:6
`define IFD_F_IODEV 5:0
`define IFD_F_GTGT 9:8
`define IFD_F_XHI 8:4
`define IFD_F_EXTB 3:2
`define IFD_F_SCLS 1:0
`define IFD_F_SIGN 15
`define IFD_F_MAG 14:0
// ----------------------------------------------------------------
// opcode and class codes
// ----------------------------------------------------------------
`define IFD_TOP_GEN 6'h00
`define IFD_OPC_SHIFT 4'h0
`define IFD_OPC_IO 4'hc
`define IFD_OPC_EXT 4'hf
`define IFD_OPC_LOADACC 4'h2
`define IFD_GTGT_VAL 2'h3
`define IFD_XHI_SPEC 5'h10
`define IFD_G_GEN 2'h0
`define IFD_G_SHIFT 2'h1
`define IFD_G_MEM 2'h2
`define IFD_G_IO 2'h3
`define IFD_K_SECT 3'h0
`define IFD_K_PREL 3'h1
`define IFD_K_LONG 3'h2
`define IFD_K_SREL 3'h3
`define IFD_K_SPOST 3'h4
`define IFD_K_SPRE 3'h5
`define IFD_K_NONE 3'h7
`define IFD_Y_LONG 2'h0
`define IFD_Y_SREL 2'h1
`define IFD_Y_SPOST 2'h2
`define IFD_Y_SPRE 2'h3
`endif

// File: design/ifd_field_dec.v
`timescale 1ns/1ps
`include "ifd_regs.vh"

module ifd_field_dec (
  input wire [15:0] word_i,
  input wire [1:0] mode_i,
  output reg [1:0] grp_o,
  output reg [2:0] cls_o,
  output reg two_word_o,
  output reg from_stack_o,
  output reg ext_bad_o,
  output reg ldacc_o
);

  // ----------------------------------------------------------------
  // one-word classification, purely combinational
  // ----------------------------------------------------------------
  reg rel;
  reg spec;
  always @* begin
    rel = mode_i[`IFD_M_REL];
    spec = rel && word_i[`IFD_F_SEC] &&
           (word_i[`IFD_F_XHI] == `IFD_XHI_SPEC); // RQ17
    grp_o = `IFD_G_MEM;
    cls_o = `IFD_K_NONE;
    two_word_o = 1'b0;
    from_stack_o = 1'b0;
    ext_bad_o = 1'b0;
    ldacc_o = 1'b0;
    if (word_i[`IFD_F_TOP] == `IFD_TOP_GEN) begin
      grp_o = `IFD_G_GEN; // RQ2
      two_word_o = (word_i[`IFD_F_GTGT] == `IFD_GTGT_VAL); // RQ3
    end else if (word_i[`IFD_F_OPC] == `IFD_OPC_SHIFT) begin
      grp_o = `IFD_G_SHIFT; // RQ4
    end else if (word_i[`IFD_F_OPC] == `IFD_OPC_IO) begin
      grp_o = `IFD_G_IO; // RQ10
    end else begin
      ldacc_o = (word_i[`IFD_F_OPC] == `IFD_OPC_LOADACC); // RQ14 RQ15
      if (!rel || !word_i[`IFD_F_SEC]) begin
        cls_o = `IFD_K_SECT; // RQ5
      end else if (!spec) begin
        cls_o = `IFD_K_PREL; // RQ5
      end else begin
        case (word_i[`IFD_F_SCLS])
          `IFD_Y_LONG: begin
            cls_o = `IFD_K_LONG;
            two_word_o = 1'b1; // RQ7
          end
          `IFD_Y_SREL: begin
            cls_o = `IFD_K_SREL;
            two_word_o = 1'b1; // RQ7
          end
          `IFD_Y_SPOST: begin
            cls_o = `IFD_K_SPOST;
            from_stack_o = 1'b1; // RQ8
          end
          default: begin
            cls_o = `IFD_K_SPRE;
            from_stack_o = 1'b1; // RQ8
          end
        endcase
      end
      // extended opcodes need a special form, hence a relative mode
      ext_bad_o = (word_i[`IFD_F_OPC] == `IFD_OPC_EXT) && !spec; // RQ9
    end
  end

endmodule // ifd_field_dec

// File: design/ifd_decoder.v
// Functional notes
// RQ1 - bit 1 is MSB; classify word combinationally
// RQ2 - generic group: whole word is opcode
// RQ3 - some generics take following word as target
// RQ4 - shift word splits opcode and shift count
// RQ5 - sectored, S=0 relative, procedure relative: one word
// RQ6 - deliver opcode, I, X, displacement to EA
// RQ7 - long reach, stack relative: two words
// RQ8 - stack post/predecrement: one word, stack value
// RQ9 - extended instructions only in relative special forms
// RQ10 - I/O bits 1-2 select four subclasses
// RQ11 - I/O bits 7-10 function, 11-16 device
// RQ12 - operands unsigned or two's complement signed
// RQ13 - double low word: bit1 zero, 15-bit extension
// RQ14 - 004000 load accumulator, 004003 addresses 3
// RQ15 - 104013 indirect, 144013 indirect plus index
// RQ16 - I bit1, X bit2, S bit7, D 8-16
// RQ17 - D -256..-241 with S set is extension
// RQ18 - flag second-word need for two-word forms
//
// The implementer's own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "ifd_regs.vh"

module ifd_decoder (
  input wire mclk_i,
  input wire sys_rst_i,
  // ahb-lite slave
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  output reg [31:0] hrdata_o,
  output reg hreadyout_o,
  output reg hresp_o,
  // instruction stream from fetch
  input wire instr_valid_i,
  input wire [15:0] instr_i,
  input wire [15:0] stack_i,
  // operand formats
  input wire opnd_valid_i,
  input wire [15:0] opnd_hi_i,
  input wire [15:0] opnd_lo_i,
  // decoded results
  output reg dec_valid_o,
  output reg need_word2_o,
  output reg [1:0] group_o,
  output reg [15:0] opcode_o,
  output reg indirect_o,
  output reg index_o,
  output reg sector_o,
  output reg [8:0] disp_o,
  output reg [2:0] addr_class_o,
  output reg [1:0] opcode_extension_bits_o,
  output reg [1:0] special_class_code_o,
  output reg [15:0] addr_value_o,
  output reg load_accumulator_op_o,
  output reg illegal_o,
  output reg [5:0] shift_count_o,
  output reg [1:0] io_subclass_o,
  output reg [3:0] io_func_o,
  output reg [5:0] io_dev_o,
  output reg opnd_neg_o,
  output reg [16:0] opnd_sext_o,
  output reg [30:0] opnd_dbl_o,
  output reg opnd_lo_bad_o
);

  localparam ST_FIRST = 1'b0;
  localparam ST_SECOND = 1'b1;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function hit;
    input [7:0] addr;
    input [7:0] off;
    begin
      hit = (addr[`IFD_A_WORD] == off[`IFD_A_WORD]);
    end
  endfunction

  // ----------------------------------------------------------------
  // control and status state
  // ----------------------------------------------------------------
  reg [2:0] ctrl_r;
  reg [31:0] cnt_r;
  reg [31:0] last_r;
  reg st_r;
  reg ap_wr_r;
  reg [7:0] ap_addr_r;

  wire [1:0] mode;
  wire en;
  assign mode = ctrl_r[`IFD_C_MODE];
  assign en = ctrl_r[`IFD_C_EN];

  // ----------------------------------------------------------------
  // word classification
  // ----------------------------------------------------------------
  wire [1:0] c_grp;
  wire [2:0] c_cls;
  wire c_two;
  wire c_stk;
  wire c_ext_bad;
  wire c_ldacc;

  // first word decoded in the cycle it is presented
  ifd_field_dec u_dec (
    .word_i(instr_i),
    .mode_i(mode),
    .grp_o(c_grp),
    .cls_o(c_cls),
    .two_word_o(c_two),
    .from_stack_o(c_stk),
    .ext_bad_o(c_ext_bad),
    .ldacc_o(c_ldacc)
  ); // RQ1

  wire take1;
  wire take2;
  assign take1 = en && instr_valid_i && (st_r == ST_FIRST);
  assign take2 = en && instr_valid_i && (st_r == ST_SECOND);

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  wire ap_take;
  wire [7:0] a_low;
  reg [31:0] rd_mux;
  assign ap_take = hsel_i && htrans_i[1] && hready_i;
  assign a_low = haddr_i[`IFD_A_LOW];

  // read mux, unmapped words read as zero
  always @* begin
    rd_mux = 32'h0000_0000;
    if (hit(a_low, `IFD_A_CTRL)) begin
      rd_mux[`IFD_C_BITS] = ctrl_r;
    end else if (hit(a_low, `IFD_A_STAT)) begin
      rd_mux[`IFD_S_WAIT] = need_word2_o;
      rd_mux[`IFD_S_ILL] = illegal_o;
      rd_mux[`IFD_S_GRP] = group_o;
    end else if (hit(a_low, `IFD_A_LAST)) begin
      rd_mux = last_r;
    end else if (hit(a_low, `IFD_A_CNT)) begin
      rd_mux = cnt_r;
    end
  end

  // address phase capture, zero-wait data phase, always okay
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ap_wr_r <= 1'b0;
      ap_addr_r <= 8'h00;
      hrdata_o <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      ap_wr_r <= ap_take && hwrite_i;
      if (ap_take) begin
        ap_addr_r <= a_low;
      end
      if (ap_take && !hwrite_i) begin
        hrdata_o <= rd_mux;
      end
    end
  end

  // control register write; mode and enable steer decoding
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_r <= `IFD_CTRL_RST;
    end else if (ap_wr_r && hit(ap_addr_r, `IFD_A_CTRL)) begin
      ctrl_r <= hwdata_i[`IFD_C_BITS];
    end
  end

  // decoded-instruction counter; a clear wins but loads a same-cycle new count
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_r <= 32'h0000_0000;
    end else if (ap_wr_r && hit(ap_addr_r, `IFD_A_CNT)) begin
      cnt_r <= {31'h0000_0000, dec_valid_o};
    end else if (dec_valid_o) begin
      cnt_r <= cnt_r + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // instruction sequencer and field outputs
  // ----------------------------------------------------------------
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_r <= ST_FIRST;
      dec_valid_o <= 1'b0;
      need_word2_o <= 1'b0;
      group_o <= `IFD_G_GEN;
      opcode_o <= 16'h0000;
      indirect_o <= 1'b0;
      index_o <= 1'b0;
      sector_o <= 1'b0;
      disp_o <= 9'h000;
      addr_class_o <= `IFD_K_NONE;
      opcode_extension_bits_o <= 2'h0;
      special_class_code_o <= 2'h0;
      addr_value_o <= 16'h0000;
      load_accumulator_op_o <= 1'b0;
      illegal_o <= 1'b0;
      shift_count_o <= 6'h00;
      io_subclass_o <= 2'h0;
      io_func_o <= 4'h0;
      io_dev_o <= 6'h00;
      last_r <= 32'h0000_0000;
    end else begin
      dec_valid_o <= 1'b0;
      if (take1) begin
        group_o <= c_grp;
        addr_class_o <= c_cls;
        illegal_o <= c_ext_bad; // RQ9
        load_accumulator_op_o <= c_ldacc; // RQ14
        last_r[`IFD_L_WORD] <= instr_i;
        // default field values, overridden per group below
        opcode_o <= 16'h0000;
        indirect_o <= 1'b0;
        index_o <= 1'b0;
        sector_o <= 1'b0;
        disp_o <= 9'h000;
        opcode_extension_bits_o <= 2'h0;
        special_class_code_o <= 2'h0;
        shift_count_o <= 6'h00;
        io_subclass_o <= 2'h0;
        io_func_o <= 4'h0;
        io_dev_o <= 6'h00;
        case (c_grp)
          `IFD_G_GEN: begin
            opcode_o <= instr_i; // RQ2
          end
          `IFD_G_SHIFT: begin
            opcode_o[`IFD_F_SOP] <= instr_i[`IFD_F_SOP]; // RQ4
            shift_count_o <= instr_i[`IFD_F_SCNT]; // RQ4
          end
          `IFD_G_IO: begin
            opcode_o[`IFD_F_TOP] <= instr_i[`IFD_F_TOP];
            io_subclass_o <= instr_i[`IFD_F_SUB]; // RQ10
            io_func_o <= instr_i[`IFD_F_IOFN]; // RQ11
            io_dev_o <= instr_i[`IFD_F_IODEV]; // RQ11
          end
          default: begin
            opcode_o[`IFD_F_OPC] <= instr_i[`IFD_F_OPC]; // RQ6
            indirect_o <= instr_i[`IFD_F_IND]; // RQ16 RQ15
            index_o <= instr_i[`IFD_F_IDX]; // RQ16 RQ15
            sector_o <= instr_i[`IFD_F_SEC]; // RQ16
            disp_o <= instr_i[`IFD_F_DISP]; // RQ16 RQ14
            if (c_cls >= `IFD_K_LONG && c_cls <= `IFD_K_SPRE) begin
              opcode_extension_bits_o <= instr_i[`IFD_F_EXTB]; // RQ7
              special_class_code_o <= instr_i[`IFD_F_SCLS]; // RQ7
            end
          end
        endcase
        if (c_two) begin
          st_r <= ST_SECOND;
          need_word2_o <= 1'b1; // RQ18
          addr_value_o <= 16'h0000;
        end else begin
          dec_valid_o <= 1'b1;
          if (c_stk) begin
            addr_value_o <= stack_i; // RQ8
            last_r[`IFD_L_ADDR] <= stack_i;
          end else begin
            addr_value_o <= 16'h0000;
            last_r[`IFD_L_ADDR] <= 16'h0000;
          end
        end
      end else if (take2) begin
        // following word is the address or target value
        addr_value_o <= instr_i; // RQ3 RQ7
        last_r[`IFD_L_ADDR] <= instr_i;
        need_word2_o <= 1'b0; // RQ18
        dec_valid_o <= 1'b1;
        st_r <= ST_FIRST;
      end
    end
  end

  // ----------------------------------------------------------------
  // operand format views
  // ----------------------------------------------------------------
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      opnd_neg_o <= 1'b0;
      opnd_sext_o <= 17'h00000;
      opnd_dbl_o <= 31'h0000_0000;
      opnd_lo_bad_o <= 1'b0;
    end else if (opnd_valid_i) begin
      opnd_neg_o <= opnd_hi_i[`IFD_F_SIGN]; // RQ12
      opnd_sext_o <= {opnd_hi_i[`IFD_F_SIGN], opnd_hi_i}; // RQ12
      opnd_dbl_o <= {opnd_hi_i, opnd_lo_i[`IFD_F_MAG]}; // RQ13
      opnd_lo_bad_o <= opnd_lo_i[`IFD_F_SIGN]; // RQ13
    end
  end

endmodule // ifd_decoder

// File: sim/ifd_fetch_model.sv
`timescale 1ns/1ps
module ifd_fetch_model (
  input wire mclk_i,
  output logic instr_valid_o,
  output logic [15:0] instr_o
);
  // ------
  // fetch side
  // ------
  // idle fetch bus at time zero
  initial begin
    instr_valid_o = 1'b0;
    instr_o = 16'h0000;
  end
  // one word for one edge, then a changed bus so stale data never matches
  task automatic put(input logic [15:0] w);
    begin
      instr_valid_o <= 1'b1;
      instr_o <= w;
      @(posedge mclk_i);
      instr_valid_o <= 1'b0;
      instr_o <= ~w;
      #1;
    end
  endtask
endmodule // ifd_fetch_model

// File: sim/ifd_decoder_asserts.sv
`timescale 1ns/1ps
module ifd_decoder_chk (
  input wire mclk_i,
  input wire sys_rst_i,
  input wire instr_valid_i,
  input wire [15:0] instr_i,
  input wire [15:0] stack_i,
  input wire opnd_valid_i,
  input wire [15:0] opnd_hi_i,
  input wire dec_valid_o,
  input wire need_word2_o,
  input wire [1:0] group_o,
  input wire [15:0] opcode_o,
  input wire indirect_o,
  input wire index_o,
  input wire [8:0] disp_o,
  input wire [2:0] addr_class_o,
  input wire [15:0] addr_value_o,
  input wire [5:0] shift_count_o,
  input wire [3:0] io_func_o,
  input wire [5:0] io_dev_o,
  input wire opnd_neg_o
);
  // ------
  // helpers
  // ------
  logic live_r;
  logic wait_r;
  wire one_w;
  // past values only trusted one edge after reset
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      live_r <= 1'b0;
      wait_r <= 1'b0;
    end else begin
      live_r <= 1'b1;
      wait_r <= need_word2_o;
    end
  end
  // a decode that finished from a single first word
  assign one_w = live_r & dec_valid_o & ~wait_r;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  // ------
  // properties
  // ------
  a_decode_cause: assert property (one_w |-> $past(instr_valid_i))
    else $error("decode without a word");
  a_generic_word: assert property (one_w && group_o == 2'h0
    |-> opcode_o == $past(instr_i)) else $error("generic opcode");
  a_word2_addr: assert property (live_r && $fell(need_word2_o)
    |-> dec_valid_o && addr_value_o == $past(instr_i))
    else $error("second word value");
  a_shift_count: assert property (one_w && group_o == 2'h1
    |-> shift_count_o == $past(instr_i[5:0])
    && opcode_o[15:6] == $past(instr_i[15:6])) else $error("shift split");
  a_memref_fields: assert property (one_w && group_o == 2'h2
    |-> indirect_o == $past(instr_i[15]) && index_o == $past(instr_i[14])
    && disp_o == $past(instr_i[8:0])) else $error("memref fields");
  a_stack_value: assert property (one_w
    && addr_class_o inside {3'h4, 3'h5}
    |-> addr_value_o == $past(stack_i)) else $error("stack value");
  a_io_fields: assert property (one_w && group_o == 2'h3
    |-> io_func_o == $past(instr_i[9:6]) && io_dev_o == $past(instr_i[5:0]))
    else $error("io fields");
  a_wait_holds: assert property (need_word2_o && !instr_valid_i
    |=> need_word2_o) else $error("wait dropped");
  a_two_word_class: assert property ($rose(need_word2_o)
    |-> addr_class_o inside {3'h2, 3'h3} || group_o == 2'h0)
    else $error("two word class");
  a_sign_bit: assert property (live_r && $past(opnd_valid_i)
    |-> opnd_neg_o == $past(opnd_hi_i[15])) else $error("sign bit");
  c_io: cover property (one_w && group_o == 2'h3);
  c_pair: cover property ($fell(need_word2_o));
  c_predec: cover property (one_w && addr_class_o == 3'h5);
endmodule // ifd_decoder_chk
bind ifd_decoder ifd_decoder_chk u_chk (.*);

// File: sim/ifd_decoder_tb.sv
`timescale 1ns/1ps
module ifd_decoder_tb;
  logic mclk_i, sys_rst_i, hsel_i, hwrite_i, opnd_valid_i;
  logic [1:0] htrans_i;
  logic [2:0] hsize_i;
  logic [31:0] haddr_i, hwdata_i, rd;
  logic [15:0] stack_i, opnd_hi_i, opnd_lo_i;
  wire instr_valid_i, hreadyout_o, hresp_o, dec_valid_o, need_word2_o;
  wire indirect_o, index_o, sector_o, load_accumulator_op_o, illegal_o;
  wire opnd_neg_o, opnd_lo_bad_o;
  wire [15:0] instr_i, opcode_o, addr_value_o;
  wire [31:0] hrdata_o;
  wire [1:0] group_o, opcode_extension_bits_o, special_class_code_o;
  wire [1:0] io_subclass_o;
  wire [8:0] disp_o;
  wire [2:0] addr_class_o;
  wire [5:0] shift_count_o, io_dev_o;
  wire [3:0] io_func_o;
  wire [16:0] opnd_sext_o;
  wire [30:0] opnd_dbl_o;
  wire hready_i = hreadyout_o;
  int num_errors, comparisons, ndec;
  logic [15:0] lw [4] = '{16'h0800, 16'h0803, 16'h880b, 16'hc80b};
  logic [11:0] lx [4] = '{12'h800, 12'h803, 12'hc0b, 12'he0b};
  ifd_decoder DUT (.*);
  ifd_fetch_model u_fetch (.mclk_i(mclk_i), .instr_valid_o(instr_valid_i),
    .instr_o(instr_i));
  // ------
  // clock and watchdog
  // ------
  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end
  initial begin
    #100000;
    num_errors++;
    final_report;
  end
  // ------
  // tasks
  // ------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      comparisons++;
      if (got !== exp) begin
        num_errors++;
        $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task automatic final_report;
    begin
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) begin
        $display("RESULT: PASS");
      end else begin
        $display("RESULT: FAIL");
      end
      $finish;
    end
  endtask
  // single ahb-lite transfer, address phase then data phase
  task automatic bus(input logic [31:0] a, input logic w,
    input logic [31:0] wd, output logic [31:0] q);
    begin
      htrans_i <= 2'h2;
      haddr_i <= a;
      hwrite_i <= w;
      do @(posedge mclk_i); while (hready_i !== 1'b1);
      htrans_i <= 2'h0;
      hwdata_i <= wd;
      do @(posedge mclk_i); while (hready_i !== 1'b1);
      q = hrdata_o;
    end
  endtask
  task automatic one(input logic [15:0] w, input logic [1:0] g,
    input logic [2:0] c);
    begin
      u_fetch.put(w);
      ndec++;
      chk({dec_valid_o, group_o, addr_class_o}, {1'b1, g, c});
    end
  endtask
  // two-word form, second word offered after a gap
  task automatic two(input logic [15:0] w1, input logic [15:0] w2,
    input logic [1:0] g, input logic [2:0] c, input int gap);
    begin
      u_fetch.put(w1);
      repeat (gap) @(posedge mclk_i);
      #1;
      chk({dec_valid_o, need_word2_o}, {1'b0, 1'b1});
      one(w2, g, c);
      chk(addr_value_o, w2);
    end
  endtask
  // ------
  // tests
  // ------
  initial begin
    num_errors = 0;
    comparisons = 0;
    ndec = 0;
    sys_rst_i = 1'b1;
    hsel_i = 1'b1;
    htrans_i = 2'h0;
    haddr_i = 32'h0;
    hwrite_i = 1'b0;
    hsize_i = 3'h2;
    hwdata_i = 32'h0;
    stack_i = 16'h5a5a;
    opnd_valid_i = 1'b0;
    opnd_hi_i = 16'h0;
    opnd_lo_i = 16'h0;
    repeat (5) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    @(posedge mclk_i);
    bus(32'h0, 1'b0, 32'h0, rd);
    chk(rd, 32'h4);
    for (int i = 0; i < 4; i++) begin
      one(lw[i], 2'h2, 3'h0);
      chk({load_accumulator_op_o, indirect_o, index_o, disp_o}, lx[i]);
    end
    one(16'h0041, 2'h0, 3'h7);
    chk(opcode_o, 16'h0041);
    two(16'h0341, 16'hbeef, 2'h0, 3'h7, 3);
    one(16'h4045, 2'h1, 3'h7);
    chk({opcode_o, shift_count_o}, {16'h4040, 6'h05});
    for (int s = 0; s < 4; s++) begin
      one({s[1:0], 4'hc, 10'h32a}, 2'h3, 3'h7);
      chk({io_subclass_o, io_func_o, io_dev_o}, {s[1:0], 10'h32a});
    end
    one(16'h0b00, 2'h2, 3'h0);
    one(16'h3f02, 2'h2, 3'h0);
    chk(illegal_o, 1'b1);
    bus(32'h4, 1'b0, 32'h0, rd);
    chk(rd, 32'ha);
    bus(32'h0, 1'b1, 32'h7, rd);
    one(16'h0b10, 2'h2, 3'h1);
    chk(sector_o, 1'b1);
    one(16'h0aff, 2'h2, 3'h1);
    one(16'h0905, 2'h2, 3'h0);
    chk(sector_o, 1'b0);
    for (int y = 0; y < 4; y++) begin
      if (y < 2) two(16'h0b0c | y, 16'h1230 + y, 2'h2, 3'h2 + y, 0);
      else one(16'h0b0c | y, 2'h2, 3'h2 + y);
      chk({opcode_extension_bits_o, special_class_code_o}, 12 + y);
    end
    chk(addr_value_o, 16'h5a5a);
    one(16'h3f0e, 2'h2, 3'h4);
    chk(illegal_o, 1'b0);
    bus(32'h8, 1'b0, 32'h0, rd);
    chk(rd, 32'h5a5a3f0e);
    bus(32'hc, 1'b0, 32'h0, rd);
    chk(rd, ndec);
    bus(32'hc, 1'b1, 32'h0, rd);
    bus(32'h10, 1'b1, 32'hffffffff, rd);
    bus(32'h10, 1'b0, 32'h0, rd);
    chk(rd, 32'h0);
    bus(32'hc, 1'b0, 32'h0, rd);
    chk(rd, 32'h0);
    chk({hreadyout_o, hresp_o}, 2'b10);
    // 32S mode: special pattern stays sectored; 32R mode: it is special
    bus(32'h0, 1'b1, 32'h5, rd);
    one(16'h3f0c, 2'h2, 3'h0);
    chk(illegal_o, 1'b1);
    bus(32'h0, 1'b1, 32'h6, rd);
    one(16'h3f0e, 2'h2, 3'h4);
    chk(illegal_o, 1'b0);
    bus(32'h0, 1'b1, 32'h3, rd);
    u_fetch.put(16'h0800);
    chk(dec_valid_o, 1'b0);
    // operand formats, negative high word then a bad low word
    opnd_valid_i <= 1'b1;
    opnd_hi_i <= 16'h8001;
    opnd_lo_i <= 16'h7fff;
    @(posedge mclk_i);
    opnd_hi_i <= 16'h1234;
    opnd_lo_i <= 16'h8000;
    #1;
    chk({opnd_neg_o, opnd_sext_o}, 18'h38001);
    chk({opnd_lo_bad_o, opnd_dbl_o}, 32'h4000ffff);
    @(posedge mclk_i);
    opnd_valid_i <= 1'b0;
    #1;
    chk({opnd_neg_o, opnd_lo_bad_o}, 2'b01);
    chk(opnd_dbl_o, 31'h091a0000);
    final_report;
  end
endmodule // ifd_decoder_tb
